// file: hw/cprc_ctrl.sv
// Internal clock generator, power-down and reset sequencer.
// Assumes mclk is the oscillator input and vec_data answers vec_rd at once.
// Operation
// - Medium-speed mode makes the internal clock from oscillator divided by eight.
// - High-speed mode divides by two and is chosen while in reset.
// - Halt-oscillator instruction stops the internal clock high and the oscillator.
// - Entering stop mode loads timer 1 with all ones.
// - Entering stop mode forces timer 1 source to oscillator divided by eight.
// - Reset or external interrupt in stop mode restarts the oscillator.
// - Internal clock stays withheld until timer 1 underflows after restart.
// - Sleep instruction stops the internal clock high, oscillator keeps running.
// - Reset or any interrupt ends wait mode with no settling delay.
// - Reset pin held low two microseconds puts the device into reset.
// - Reset ends when the pin returns high; no execution while low.
// - Start address high byte from top location, low byte just below.
`timescale 1ns/1ns
`default_nettype none
`include "cprc_map.svh"

module cprc_ctrl (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        reset_n_pin,
	input  wire logic        ext_irq_pin,
	input  wire logic        int_req,
	input  wire logic        speed_med,
	input  wire logic        halt_osc_instruction,
	input  wire logic        sleep_keep_osc_instruction,
	input  wire logic [7:0]  vec_data,
	output var  logic        cpu_clk,
	output var  logic        osc_output_en,
	output var  logic        cpu_reset,
	output var  logic        t1_src_forced,
	output var  logic [7:0]  t1_count,
	output var  logic [15:0] vec_addr,
	output var  logic        vec_rd,
	output var  logic [15:0] start_pc,
	output var  logic        start_valid
);

	localparam logic [6:0] RST_MIN = 7'(`CPRC_RST_MIN_CYC);
	localparam logic [2:0] T1_TOP = 3'(`CPRC_T1_DIV - 1);

	function automatic logic [1:0] cprc_half_top(input logic med);
		cprc_half_top = med ? 2'(`CPRC_DIV_MED / 2 - 1)
			: 2'(`CPRC_DIV_HIGH / 2 - 1);
	endfunction : cprc_half_top

	cprc_pkg::cprc_state_t state_reg;
	cprc_pkg::cprc_state_t state_next;
	logic        rstn_s1_reg;
	logic        rstn_s2_reg;
	logic        irq_s1_reg;
	logic        irq_s2_reg;
	logic [6:0]  rlow_cnt_reg;
	logic [6:0]  rlow_cnt_next;
	logic        phi_reg;
	logic        phi_next;
	logic [1:0]  div_cnt_reg;
	logic [1:0]  div_cnt_next;
	logic        ratio_med_reg;
	logic        ratio_med_next;
	logic [2:0]  pre_cnt_reg;
	logic [2:0]  pre_cnt_next;
	logic        osc_run_reg;
	logic        osc_run_next;
	logic        cpu_reset_reg;
	logic        cpu_reset_next;
	logic        t1_force_reg;
	logic        t1_force_next;
	logic [15:0] vec_addr_reg;
	logic [15:0] vec_addr_next;
	logic        vec_rd_reg;
	logic        vec_rd_next;
	logic [7:0]  vec_lo_reg;
	logic [7:0]  vec_lo_next;
	logic [15:0] start_pc_reg;
	logic [15:0] start_pc_next;
	logic        start_valid_reg;
	logic        start_valid_next;
	logic        rst_low;
	logic        rst_hold;
	logic        gate;
	logic        t1_load;
	logic        t1_tick;
	logic        t1_uf;
	logic [7:0]  t1_cnt;

	// Two-stage synchronisers for the pin inputs.
	always_ff @(posedge mclk) begin
		if (rst) begin
			rstn_s1_reg <= 1'b0;
			rstn_s2_reg <= 1'b0;
			irq_s1_reg  <= 1'b0;
			irq_s2_reg  <= 1'b0;
		end else begin
			rstn_s1_reg <= reset_n_pin;
			rstn_s2_reg <= rstn_s1_reg;
			irq_s1_reg  <= ext_irq_pin;
			irq_s2_reg  <= irq_s1_reg;
		end
	end

	assign rst_low  = !rstn_s2_reg;
	assign rst_hold = (rlow_cnt_reg == RST_MIN);
	assign gate     = (state_reg == cprc_pkg::CPRC_STOP)
		|| (state_reg == cprc_pkg::CPRC_SETTLE)
		|| (state_reg == cprc_pkg::CPRC_WAIT);
	assign t1_tick  = (state_reg == cprc_pkg::CPRC_SETTLE)
		&& (pre_cnt_reg == T1_TOP);

	// Clock divider, low-time filter and timer prescaler.
	always_comb begin
		phi_next       = phi_reg;
		div_cnt_next   = div_cnt_reg;
		ratio_med_next = ratio_med_reg;
		rlow_cnt_next  = rst_low ? (rst_hold ? rlow_cnt_reg
			: rlow_cnt_reg + 7'h01) : 7'h00;
		pre_cnt_next   = t1_load ? 3'h0 : pre_cnt_reg + 3'h1;
		if (gate && phi_reg) begin
			phi_next     = 1'b1;
			div_cnt_next = 2'h0;
		end else if (div_cnt_reg == cprc_half_top(ratio_med_reg)) begin
			phi_next     = !phi_reg;
			div_cnt_next = 2'h0;
			if (!phi_reg) begin
				ratio_med_next = cpu_reset_reg ? 1'b0 : speed_med;
			end
		end else begin
			div_cnt_next = div_cnt_reg + 2'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			phi_reg       <= 1'b1;
			div_cnt_reg   <= 2'h0;
			ratio_med_reg <= 1'b0;
			rlow_cnt_reg  <= 7'h00;
			pre_cnt_reg   <= 3'h0;
		end else begin
			phi_reg       <= phi_next;
			div_cnt_reg   <= div_cnt_next;
			ratio_med_reg <= ratio_med_next;
			rlow_cnt_reg  <= rlow_cnt_next;
			pre_cnt_reg   <= pre_cnt_next;
		end
	end

	// Power-down and reset sequencer.
	always_comb begin
		state_next       = state_reg;
		osc_run_next     = osc_run_reg;
		cpu_reset_next   = cpu_reset_reg;
		t1_force_next    = t1_force_reg;
		vec_addr_next    = vec_addr_reg;
		vec_rd_next      = vec_rd_reg;
		vec_lo_next      = vec_lo_reg;
		start_pc_next    = start_pc_reg;
		start_valid_next = 1'b0;
		t1_load          = 1'b0;
		case (state_reg)
			cprc_pkg::CPRC_RUN: begin
				if (rst_hold) begin
					state_next     = cprc_pkg::CPRC_RESET;
					cpu_reset_next = 1'b1;
				end else if (halt_osc_instruction) begin
					state_next    = cprc_pkg::CPRC_STOP;
					osc_run_next  = 1'b0;
					t1_load       = 1'b1;
					t1_force_next = 1'b1;
				end else if (sleep_keep_osc_instruction) begin
					state_next = cprc_pkg::CPRC_WAIT;
				end
			end
			cprc_pkg::CPRC_STOP: begin
				if (rst_low || irq_s2_reg) begin
					state_next   = cprc_pkg::CPRC_SETTLE;
					osc_run_next = 1'b1;
				end
			end
			cprc_pkg::CPRC_SETTLE: begin
				if (t1_uf) begin
					t1_force_next = 1'b0;
					if (rst_low) begin
						state_next     = cprc_pkg::CPRC_RESET;
						cpu_reset_next = 1'b1;
					end else begin
						state_next = cprc_pkg::CPRC_RUN;
					end
				end
			end
			cprc_pkg::CPRC_WAIT: begin
				if (rst_hold) begin
					state_next     = cprc_pkg::CPRC_RESET;
					cpu_reset_next = 1'b1;
				end else if (int_req || irq_s2_reg) begin
					state_next = cprc_pkg::CPRC_RUN;
				end
			end
			cprc_pkg::CPRC_RESET: begin
				cpu_reset_next = 1'b1;
				if (!rst_low) begin
					state_next    = cprc_pkg::CPRC_FETCH_LO;
					vec_addr_next = `CPRC_VEC_LO;
					vec_rd_next   = 1'b1;
				end
			end
			cprc_pkg::CPRC_FETCH_LO: begin
				vec_lo_next   = vec_data;
				vec_addr_next = `CPRC_VEC_HI;
				state_next    = cprc_pkg::CPRC_FETCH_HI;
			end
			cprc_pkg::CPRC_FETCH_HI: begin
				start_pc_next    = {vec_data, vec_lo_reg};
				start_valid_next = 1'b1;
				vec_rd_next      = 1'b0;
				cpu_reset_next   = 1'b0;
				state_next       = cprc_pkg::CPRC_RUN;
			end
			default: begin
				state_next     = cprc_pkg::CPRC_RESET;
				cpu_reset_next = 1'b1;
			end
		endcase
		if (rst_hold && (state_reg == cprc_pkg::CPRC_FETCH_LO
			|| state_reg == cprc_pkg::CPRC_FETCH_HI)) begin
			state_next       = cprc_pkg::CPRC_RESET;
			cpu_reset_next   = 1'b1;
			vec_rd_next      = 1'b0;
			start_valid_next = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg       <= cprc_pkg::CPRC_RESET;
			osc_run_reg     <= 1'b1;
			cpu_reset_reg   <= 1'b1;
			t1_force_reg    <= 1'b0;
			vec_addr_reg    <= 16'h0000;
			vec_rd_reg      <= 1'b0;
			vec_lo_reg      <= 8'h00;
			start_pc_reg    <= 16'h0000;
			start_valid_reg <= 1'b0;
		end else begin
			state_reg       <= state_next;
			osc_run_reg     <= osc_run_next;
			cpu_reset_reg   <= cpu_reset_next;
			t1_force_reg    <= t1_force_next;
			vec_addr_reg    <= vec_addr_next;
			vec_rd_reg      <= vec_rd_next;
			vec_lo_reg      <= vec_lo_next;
			start_pc_reg    <= start_pc_next;
			start_valid_reg <= start_valid_next;
		end
	end

	cprc_timer1 #(
		.W (8)
	) u_timer1 (
		.mclk       (mclk),
		.rst        (rst),
		.load       (t1_load),
		.load_value (`CPRC_T1_INIT),
		.tick       (t1_tick),
		.count      (t1_cnt),
		.underflow  (t1_uf)
	);

	assign cpu_clk       = phi_reg;
	assign osc_output_en = osc_run_reg;
	assign cpu_reset     = cpu_reset_reg;
	assign t1_src_forced = t1_force_reg;
	assign t1_count      = t1_cnt;
	assign vec_addr      = vec_addr_reg;
	assign vec_rd        = vec_rd_reg;
	assign start_pc      = start_pc_reg;
	assign start_valid   = start_valid_reg;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_med_high_half: assert property ($rose(phi_reg) && ratio_med_reg
		|-> phi_reg[*4]) else $error("medium high half short");
	a_reset_ratio_high: assert property (cpu_reset_reg && $rose(phi_reg)
		&& $past(cpu_reset_reg) |-> !ratio_med_reg)
		else $error("ratio not high speed in reset");
	a_stop_clk_osc: assert property (state_reg == cprc_pkg::CPRC_STOP
		&& phi_reg |-> !osc_run_reg ##1 phi_reg)
		else $error("stop not halted");
	a_stop_t1_load: assert property (state_reg == cprc_pkg::CPRC_RUN
		&& halt_osc_instruction && !rst_hold
		|=> t1_cnt == 8'hff && t1_force_reg)
		else $error("timer 1 not loaded");
	a_stop_t1_src: assert property (state_reg == cprc_pkg::CPRC_SETTLE
		&& pre_cnt_reg == 3'h0 |-> !t1_tick ##7 t1_tick)
		else $error("timer 1 source not div8");
	a_stop_wake_osc: assert property (state_reg == cprc_pkg::CPRC_STOP
		&& irq_s2_reg |=> osc_run_reg)
		else $error("oscillator not restarted");
	a_settle_withhold: assert property (state_reg == cprc_pkg::CPRC_SETTLE
		&& !t1_uf |=> phi_reg) else $error("clock leaked");
	a_wait_osc_run: assert property (state_reg == cprc_pkg::CPRC_WAIT
		&& phi_reg |-> osc_run_reg ##1 phi_reg)
		else $error("wait state wrong");
	a_wait_wake: assert property (state_reg == cprc_pkg::CPRC_WAIT
		&& int_req && !rst_hold |=> state_reg == cprc_pkg::CPRC_RUN)
		else $error("wait not released");
	a_rst_enter: assert property (state_reg == cprc_pkg::CPRC_RUN
		&& rst_hold |=> cpu_reset_reg) else $error("reset missed");
	a_rst_no_exec: assert property (state_reg == cprc_pkg::CPRC_RESET
		&& rst_low |=> cpu_reset_reg && !start_valid_reg)
		else $error("executed in reset");
	a_vec_order: assert property (state_reg == cprc_pkg::CPRC_FETCH_LO
		&& !rst_hold |-> vec_addr_reg == 16'hfffe && vec_rd_reg
		##1 vec_addr_reg == 16'hffff ##1 start_valid_reg
		&& start_pc_reg == {$past(vec_data), $past(vec_data, 2)})
		else $error("vector fetch wrong");
	a_ratio_at_rise: assert property ($changed(ratio_med_reg)
		|-> $rose(phi_reg)) else $error("ratio changed mid pulse");

	c_stop_wake: cover property (state_reg == cprc_pkg::CPRC_SETTLE
		##1 state_reg == cprc_pkg::CPRC_RUN);
	c_wait_wake: cover property (state_reg == cprc_pkg::CPRC_WAIT
		##1 state_reg == cprc_pkg::CPRC_RUN);
	c_fetch_done: cover property (start_valid_reg);
	c_med_mode: cover property ($rose(phi_reg) && ratio_med_reg);

endmodule : cprc_ctrl

`default_nettype wire

// file: hw/cprc_map.svh
// Constants for the clock, power-down and reset controller.
// Assumes a 25 MHz mclk that stands for the oscillator input.
`ifndef CPRC_MAP_SVH
`define CPRC_MAP_SVH

`define CPRC_CLK_NS      40
`define CPRC_DIV_HIGH    2
`define CPRC_DIV_MED     8
`define CPRC_T1_DIV      8
`define CPRC_T1_INIT     8'hff
`define CPRC_VEC_LO      16'hfffe
`define CPRC_VEC_HI      16'hffff
`define CPRC_RST_MIN_NS  2000
`define CPRC_RST_MIN_CYC ((`CPRC_RST_MIN_NS + `CPRC_CLK_NS - 1) / `CPRC_CLK_NS)

`endif

// file: hw/cprc_pkg.sv
// Types for the clock, power-down and reset controller.
// Assumes nothing beyond a SystemVerilog compiler.
package cprc_pkg;

	typedef enum logic [2:0] {
		CPRC_RUN,
		CPRC_STOP,
		CPRC_SETTLE,
		CPRC_WAIT,
		CPRC_RESET,
		CPRC_FETCH_LO,
		CPRC_FETCH_HI
	} cprc_state_t;

endpackage : cprc_pkg

// file: hw/cprc_timer1.sv
// Timer 1 as used for the oscillator restart delay.
// Assumes load and tick come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none

module cprc_timer1 #(
	parameter int W = 8
) (
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic         load,
	input  wire logic [W-1:0] load_value,
	input  wire logic         tick,
	output var  logic [W-1:0] count,
	output var  logic         underflow
);

	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;

	always_comb begin
		count_next = count_reg;
		underflow  = tick && (count_reg == '0) && !load;
		if (load) begin
			count_next = load_value;
		end else if (underflow) begin
			count_next = load_value;
		end else if (tick) begin
			count_next = count_reg - W'(1);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			count_reg <= '1;
		end else begin
			count_reg <= count_next;
		end
	end

	assign count = count_reg;

endmodule : cprc_timer1

`default_nettype wire

// file: sim/cprc_far_model.sv
// Far side model: reset driver, external interrupt line, vector memory.
// Assumes the bench calls its tasks just after a rising mclk edge.
`timescale 1ns/1ns
`default_nettype none

module cprc_far_model #(
	parameter logic [7:0] VEC_LO = 8'h34,
	parameter logic [7:0] VEC_HI = 8'h12
) (
	input  wire logic        mclk,
	input  wire logic [15:0] vec_addr,
	input  wire logic        vec_rd,
	output var  logic        reset_n_pin,
	output var  logic        ext_irq_pin,
	output var  logic [7:0]  vec_data
);
	logic [7:0] junk_reg = 8'h5a;

	initial begin
		reset_n_pin = 1'b0;
		ext_irq_pin = 1'b0;
	end

	// Unselected memory shows a pattern that changes every cycle.
	always @(posedge mclk) begin
		junk_reg <= ~junk_reg + 8'h01;
	end

	// Low byte sits just below the top location, high byte on top.
	always_comb begin
		vec_data = junk_reg;
		if (vec_rd && vec_addr == 16'hfffe) begin
			vec_data = VEC_LO;
		end
		if (vec_rd && vec_addr == 16'hffff) begin
			vec_data = VEC_HI;
		end
	end

	// A real reset needs the pin low for 50 cycles or more.
	task automatic set_pin(input logic v);
		reset_n_pin = v;
	endtask : set_pin

	task automatic set_irq(input logic v);
		ext_irq_pin = v;
	endtask : set_irq

endmodule : cprc_far_model

`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the clock, power-down and reset controller.
// Assumes the far side model supplies the pins and the vector memory.
`timescale 1ns/1ns
`default_nettype none

module testbench;
	localparam logic [7:0] LO = 8'h34;
	localparam logic [7:0] HI = 8'h12;

	logic        mclk;
	logic        rst;
	logic        int_req;
	logic        speed_med;
	logic        halt;
	logic        sleep;
	logic        reset_n_pin;
	logic        ext_irq_pin;
	logic [7:0]  vec_data;
	logic        cpu_clk;
	logic        osc_output_en;
	logic        cpu_reset;
	logic        t1_src_forced;
	logic [7:0]  t1_count;
	logic [15:0] vec_addr;
	logic        vec_rd;
	logic [15:0] start_pc;
	logic        start_valid;
	int          failures = 0;
	int          checks_done = 0;

	cprc_ctrl DUT (
		.mclk                       (mclk),
		.rst                        (rst),
		.reset_n_pin                (reset_n_pin),
		.ext_irq_pin                (ext_irq_pin),
		.int_req                    (int_req),
		.speed_med                  (speed_med),
		.halt_osc_instruction       (halt),
		.sleep_keep_osc_instruction (sleep),
		.vec_data                   (vec_data),
		.cpu_clk                    (cpu_clk),
		.osc_output_en              (osc_output_en),
		.cpu_reset                  (cpu_reset),
		.t1_src_forced              (t1_src_forced),
		.t1_count                   (t1_count),
		.vec_addr                   (vec_addr),
		.vec_rd                     (vec_rd),
		.start_pc                   (start_pc),
		.start_valid                (start_valid)
	);

	cprc_far_model #(.VEC_LO(LO), .VEC_HI(HI)) far (
		.mclk        (mclk),
		.vec_addr    (vec_addr),
		.vec_rd      (vec_rd),
		.reset_n_pin (reset_n_pin),
		.ext_irq_pin (ext_irq_pin),
		.vec_data    (vec_data)
	);

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic step();
		@(posedge mclk);
		#1;
	endtask : step

	task automatic stop_test();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	function automatic logic pick(input int w);
		case (w)
			0: return cpu_clk;
			1: return start_valid;
			3: return vec_rd;
			default: return osc_output_en;
		endcase
	endfunction : pick

	// Waits for a level with a bound; a timeout ends the run.
	task automatic wait_sig(input int w, input logic v, output int n);
		for (n = 0; pick(w) !== v; n++) begin
			if (n == 3000) begin
				failures++;
				stop_test();
			end
			step();
		end
	endtask : wait_sig

	// Measures high time and period of the internal clock.
	task automatic ratio(input int hi_exp, input int per_exp);
		int h;
		int l;
		wait_sig(0, 1'b0, h);
		wait_sig(0, 1'b1, h);
		wait_sig(0, 1'b0, h);
		wait_sig(0, 1'b1, l);
		chk(16'(h), 16'(hi_exp));
		chk(16'(h + l), 16'(per_exp));
	endtask : ratio

	task automatic boot_fetch();
		int n;
		repeat (10) step();
		chk(cpu_reset, 1'b1);
		far.set_pin(1'b1);
		wait_sig(3, 1'b1, n);
		chk(vec_addr, 16'hfffe);
		step();
		chk(vec_addr, 16'hffff);
		chk(vec_rd, 1'b1);
		wait_sig(1, 1'b1, n);
		chk(start_pc, {HI, LO});
		chk(cpu_reset, 1'b0);
		ratio(1, 2);
		speed_med = 1'b1;
		ratio(4, 8);
	endtask : boot_fetch

	task automatic stop_mode();
		int n;
		halt = 1'b1;
		step();
		halt = 1'b0;
		chk(osc_output_en, 1'b0);
		chk(t1_src_forced, 1'b1);
		chk(t1_count, 8'hff);
		repeat (40) step();
		chk(cpu_clk, 1'b1);
		far.set_irq(1'b1);
		wait_sig(2, 1'b1, n);
		chk(n < 6, 1'b1);
		far.set_irq(1'b0);
		wait_sig(0, 1'b0, n);
		chk(n > 2040, 1'b1);
		chk(t1_src_forced, 1'b0);
	endtask : stop_mode

	task automatic wait_mode();
		int n;
		int h = 0;
		sleep = 1'b1;
		step();
		sleep = 1'b0;
		repeat (8) step();
		repeat (16) begin
			step();
			h += cpu_clk;
		end
		chk(16'(h), 16'd16);
		chk(osc_output_en, 1'b1);
		int_req = 1'b1;
		step();
		int_req = 1'b0;
		wait_sig(0, 1'b0, n);
		chk(n < 6, 1'b1);
		sleep = 1'b1;
		step();
		sleep = 1'b0;
		repeat (8) step();
		chk(cpu_clk, 1'b1);
		far.set_irq(1'b1);
		wait_sig(0, 1'b0, n);
		far.set_irq(1'b0);
		chk(n < 9, 1'b1);
	endtask : wait_mode

	task automatic pin_reset();
		int n;
		int r = 0;
		far.set_pin(1'b0);
		for (n = 0; n < 40; n++) begin
			if (n == 30) begin
				far.set_pin(1'b1);
			end
			step();
			r += cpu_reset;
		end
		chk(16'(r), 16'd0);
		far.set_pin(1'b0);
		repeat (60) step();
		chk(cpu_reset, 1'b1);
		ratio(1, 2);
		far.set_pin(1'b1);
		wait_sig(1, 1'b1, n);
		chk(start_pc, {HI, LO});
		chk(cpu_reset, 1'b0);
		halt = 1'b1;
		step();
		halt = 1'b0;
		far.set_pin(1'b0);
		wait_sig(2, 1'b1, n);
		chk(n < 6, 1'b1);
		far.set_pin(1'b1);
		wait_sig(0, 1'b0, n);
		chk(n > 2040, 1'b1);
		chk(cpu_reset, 1'b0);
	endtask : pin_reset

	initial begin
		rst = 1'b1;
		int_req = 1'b0;
		speed_med = 1'b0;
		halt = 1'b0;
		sleep = 1'b0;
		repeat (4) step();
		rst = 1'b0;
		boot_fetch();
		stop_mode();
		wait_mode();
		pin_reset();
		stop_test();
	end

endmodule : testbench

`default_nettype wire
